// file: shared/mdc_pkg.sv
// Shared constants for the multiply / divide / accumulate coprocessor
package mdc_pkg;

   // Operand and result widths
   localparam int unsigned DATA_W = 16;
   localparam int unsigned RES_W = 32;
   localparam int unsigned MODE_W = 7;

   // Mode word layout: output select in the upper field, operation below
   localparam int unsigned MODE_OP_LSB = 0;
   localparam int unsigned MODE_OP_MSB = 3;
   localparam int unsigned MODE_SEL_LSB = 4;
   localparam int unsigned MODE_SEL_MSB = 6;

   // Reset values of the stored state
   localparam logic [6:0] MODE_RESET = 7'h00;
   localparam logic [31:0] RES_RESET = 32'h0000_0000;

   // Output half selection codes
   localparam logic [2:0] SEL_LOW = 3'h0;
   localparam logic [2:0] SEL_HIGH = 3'h1;

   // Flag nibble returned with each answer, ordered C V Z N from bit 3 down
   localparam int unsigned FLAG_C = 3;
   localparam int unsigned FLAG_V = 2;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 0;
   localparam logic [3:0] FLAGS_CLEAR = 4'h0;

   // Operation codes held in the low mode field
   typedef enum logic [3:0] {
      OP_CLEAR = 4'h0,
      OP_INIT16 = 4'h1,
      OP_INIT32 = 4'h2,
      OP_READ = 4'h3,
      OP_UMUL = 4'h4,
      OP_SMUL = 4'h5,
      OP_SMAC = 4'h7,
      OP_UDIV = 4'h8,
      OP_SDIV = 4'h9
   } mdc_op_e;

   // Divider timing: one step per quotient bit
   localparam logic [4:0] DIV_STEPS = 5'h10;
   // Cycles from operand acceptance to the answer of a division
   localparam int unsigned DIV_LATENCY = 19;

endpackage

// file: hdl/mdc_divider.sv
`timescale 1ns/1ps
// Iterative restoring divider, 16 by 16 bit, signed or unsigned
module mdc_divider (
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic start,
   input wire logic signed_mode,
   input wire logic [15:0] dividend,
   input wire logic [15:0] divisor,
   output logic done,
   output logic [15:0] quotient,
   output logic [15:0] remainder
);

   // Divider sequencing states
   typedef enum logic [1:0] {
      DIV_IDLE = 2'b00,
      DIV_RUN = 2'b01,
      DIV_FIX = 2'b10
   } mdc_div_e;

   // Whole divider state in one record
   typedef struct packed {
      mdc_div_e state;
      logic [4:0] cnt;       // Steps taken so far
      logic [16:0] part;     // Partial remainder, one spare bit for the compare
      logic [15:0] quo;      // Dividend shifting out, quotient shifting in
      logic [15:0] dsr;      // Divisor magnitude
      logic neg_q;           // Quotient must be negated at the end
      logic neg_r;           // Remainder takes the dividend's sign
      logic done;            // One-cycle completion pulse
      logic [15:0] q_out;    // Final quotient
      logic [15:0] r_out;    // Final remainder
   } mdc_div_s;

   mdc_div_s st_reg;
   mdc_div_s st_next;
   logic [16:0] shifted;     // Partial remainder after the shift
   logic [16:0] trial;       // Trial subtraction

   // Next-state logic for the divider
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      shifted = {st_reg.part[15:0], st_reg.quo[15]};
      trial = shifted - {1'b0, st_reg.dsr};
      case (st_reg.state)
         DIV_IDLE: begin
            if (start) begin
               // Work on magnitudes; signs are restored at the end
               st_next.neg_q = signed_mode & (dividend[15] ^ divisor[15]);
               st_next.neg_r = signed_mode & dividend[15];
               st_next.quo = (signed_mode & dividend[15]) ? 16'(-dividend) : dividend;
               st_next.dsr = (signed_mode & divisor[15]) ? 16'(-divisor) : divisor;
               st_next.part = 17'h0_0000;
               st_next.cnt = 5'h00;
               st_next.state = DIV_RUN;
            end
         end
         DIV_RUN: begin
            // Keep the difference only when it did not go negative
            if (!trial[16]) begin
               st_next.part = trial;
               st_next.quo = {st_reg.quo[14:0], 1'b1};
            end else begin
               st_next.part = shifted;
               st_next.quo = {st_reg.quo[14:0], 1'b0};
            end
            st_next.cnt = st_reg.cnt + 5'h01;
            if (st_reg.cnt == mdc_pkg::DIV_STEPS - 5'h01) begin
               st_next.state = DIV_FIX;
            end
         end
         DIV_FIX: begin
            // Truncating division: remainder follows the dividend's sign
            st_next.q_out = st_reg.neg_q ? 16'(-st_reg.quo) : st_reg.quo;
            st_next.r_out = st_reg.neg_r ? 16'(-st_reg.part[15:0]) : st_reg.part[15:0];
            st_next.done = 1'b1;
            st_next.state = DIV_IDLE;
         end
         default: begin
            st_next.state = DIV_IDLE;
         end
      endcase
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;
   assign quotient = st_reg.q_out;
   assign remainder = st_reg.r_out;

endmodule

// file: hdl/mdc_coproc.sv
`timescale 1ns/1ps
// Functional notes
// - Multiply 16x16 to 32 bits in one cycle
// - Signed accumulate into result, detect overflow
// - Divide 16/16, quotient and remainder, 17-20 cycles
// - Core writes mode word; device stores it
// - Mode from source bits 6:0, destination ignored
// - Select field picks low or high half
// - Operation code 0 clears whole result
// - Code 1 loads 16-bit initial value low
// - Code 2 loads full 32-bit initial value
// - Code 3 returns stored half, no arithmetic
// - Codes 4/5 multiply, product overwrites result
// - Code 7 adds product to stored result
// - Operand send answers selected half plus flags
// - Result held until a later operation
// - Codes 8/9 divide with sent operands
// - Quotient low half, remainder high half
// - Accumulate reports overflow only, other flags zero
module mdc_coproc (
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic coproc_mode_write_instr,
   input wire logic coproc_operand_send_instr,
   input wire logic coproc_initial_load_instr,
   input wire logic [15:0] cop_dst,
   input wire logic [15:0] cop_src,
   output logic cop_ready,
   output logic cop_ans_valid,
   output logic [15:0] cop_ans_data,
   output logic [3:0] cop_ans_flags,
   output logic [6:0] cop_mode
);

   // Whole coprocessor state in one record
   typedef struct packed {
      logic [6:0] mode;        // Operation and output select word
      logic [31:0] res;        // Operation result register
      logic [15:0] ans_data;   // Half returned to the core
      logic [3:0] ans_flags;   // C V Z N returned to the core
      logic ans_valid;         // One-cycle answer strobe
      logic busy;              // Division in flight
   } mdc_core_s;

   mdc_core_s st_reg;
   mdc_core_s st_next;

   // Decoded fields of the stored mode word
   mdc_pkg::mdc_op_e op;
   logic [2:0] sel;

   // Arithmetic results, all combinational from the sent operands and the stored result
   logic [31:0] prod_u;        // Unsigned product
   logic signed [31:0] prod_s; // Signed product
   logic [32:0] mac_sum;       // Accumulation with one guard bit
   logic mac_ovf;              // Accumulation left the 32-bit signed range

   // Strobes accepted only while no division is running
   logic mode_take;
   logic send_take;
   logic load_take;

   // Divider handshake
   logic div_start;
   logic div_done;
   logic [15:0] div_quo;
   logic [15:0] div_rem;
   logic [31:0] div_res;

   // Picks the 16-bit half that the output select asks
   function automatic logic [15:0] pick_half(input logic [2:0] s, input logic [31:0] v);
      logic [15:0] h;
      // Reserved selections fall back to the low half
      if (s == mdc_pkg::SEL_HIGH) begin
         h = v[31:16];
      end else begin
         h = v[15:0];
      end
      return h;
   endfunction

   // Mode fields
   assign op = mdc_pkg::mdc_op_e'(st_reg.mode[mdc_pkg::MODE_OP_MSB:mdc_pkg::MODE_OP_LSB]);
   assign sel = st_reg.mode[mdc_pkg::MODE_SEL_MSB:mdc_pkg::MODE_SEL_LSB];

   // Single-cycle multiplier, both signednesses side by side
   assign prod_u = {16'h0000, cop_dst} * {16'h0000, cop_src};
   assign prod_s = $signed(cop_dst) * $signed(cop_src);

   // Accumulator with sign-extended guard bit
   assign mac_sum = {prod_s[31], prod_s} + {st_reg.res[31], st_reg.res};
   // Overflow shows as disagreement between guard and top bit
   assign mac_ovf = mac_sum[32] ^ mac_sum[31];

   // Every strobe waits behind a running division; the core sees ready low
   assign mode_take = coproc_mode_write_instr & ~st_reg.busy;
   assign send_take = coproc_operand_send_instr & ~st_reg.busy;
   assign load_take = coproc_initial_load_instr & ~st_reg.busy;

   // Division starts on an operand send in either divide mode
   assign div_start = send_take & ((op == mdc_pkg::OP_UDIV) | (op == mdc_pkg::OP_SDIV));

   // Quotient in the low half, remainder in the high half
   assign div_res = {div_rem, div_quo};

   // Iterative divider; its done pulse comes 18 cycles after start, the answer register adds the 19th
   mdc_divider u_div (
      .clock(clock),
      .srst(srst),
      .clk_en(clk_en),
      .start(div_start),
      .signed_mode(op == mdc_pkg::OP_SDIV),
      .dividend(cop_dst),
      .divisor(cop_src),
      .done(div_done),
      .quotient(div_quo),
      .remainder(div_rem)
   );

   // Next-state logic: mode writes, initial loads, operand sends, division end
   always_comb begin
      st_next = st_reg;
      // Answer strobe lasts exactly one cycle
      st_next.ans_valid = 1'b0;

      if (mode_take) begin
         // Only source bits 6:0 matter; the destination is not looked at
         st_next.mode = cop_src[6:0];
         // Writing the clear code wipes the result with no further send
         if (cop_src[3:0] == mdc_pkg::OP_CLEAR) begin
            st_next.res = mdc_pkg::RES_RESET;
         end
      end else if (load_take) begin
         // Initial values arrive on the load instruction only
         if (op == mdc_pkg::OP_INIT16) begin
            // Upper half cleared, source into the lower half
            st_next.res = {16'h0000, cop_src};
         end else if (op == mdc_pkg::OP_INIT32) begin
            // Destination high, source low
            st_next.res = {cop_dst, cop_src};
         end
      end else if (send_take) begin
         // Flags move only with an answer, so a send that answers nothing keeps them
         case (op)
            mdc_pkg::OP_READ: begin
               // Stored result returned untouched
               st_next.ans_data = pick_half(sel, st_reg.res);
               st_next.ans_flags = mdc_pkg::FLAGS_CLEAR;
               st_next.ans_valid = 1'b1;
            end
            mdc_pkg::OP_UMUL: begin
               // Product overwrites the result register
               st_next.res = prod_u;
               st_next.ans_data = pick_half(sel, prod_u);
               st_next.ans_flags = mdc_pkg::FLAGS_CLEAR;
               st_next.ans_valid = 1'b1;
            end
            mdc_pkg::OP_SMUL: begin
               // Signed product overwrites the result register
               st_next.res = prod_s;
               st_next.ans_data = pick_half(sel, prod_s);
               st_next.ans_flags = mdc_pkg::FLAGS_CLEAR;
               st_next.ans_valid = 1'b1;
            end
            mdc_pkg::OP_SMAC: begin
               // Product added to what the register already holds
               st_next.res = mac_sum[31:0];
               st_next.ans_data = pick_half(sel, mac_sum[31:0]);
               // Only the overflow flag may be raised
               st_next.ans_flags = mdc_pkg::FLAGS_CLEAR;
               st_next.ans_flags[mdc_pkg::FLAG_V] = mac_ovf;
               st_next.ans_valid = 1'b1;
            end
            mdc_pkg::OP_UDIV, mdc_pkg::OP_SDIV: begin
               // Hold off the core until the quotient is ready
               st_next.busy = 1'b1;
            end
            default: begin
               // Clear and load codes give no answer on a send; the result is kept
               st_next.res = st_reg.res;
            end
         endcase
      end

      // Division end: store both halves, answer, release the core
      if (st_reg.busy && div_done) begin
         st_next.res = div_res;
         st_next.ans_data = pick_half(sel, div_res);
         st_next.ans_flags = mdc_pkg::FLAGS_CLEAR;
         st_next.ans_valid = 1'b1;
         st_next.busy = 1'b0;
      end
   end

   // State register; clock enable low freezes everything including the result
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg.mode <= mdc_pkg::MODE_RESET;
         st_reg.res <= mdc_pkg::RES_RESET;
         st_reg.ans_data <= 16'h0000;
         st_reg.ans_flags <= mdc_pkg::FLAGS_CLEAR;
         st_reg.ans_valid <= 1'b0;
         st_reg.busy <= 1'b0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // Ready is the inverted busy flop, so it falls one cycle after a divide send is taken
   assign cop_ready = ~st_reg.busy;
   // Answer outputs come straight from flip-flops
   assign cop_ans_valid = st_reg.ans_valid;
   assign cop_ans_data = st_reg.ans_data;
   assign cop_ans_flags = st_reg.ans_flags;
   // Stored mode made visible; software cannot read it back otherwise
   assign cop_mode = st_reg.mode;

endmodule

// file: tb/mdc_coproc_asserts.sv
`timescale 1ns/1ps
// Port-level checker for the coprocessor; one clock domain
module mdc_coproc_asserts (
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic coproc_mode_write_instr,
   input wire logic coproc_operand_send_instr,
   input wire logic coproc_initial_load_instr,
   input wire logic [15:0] cop_dst,
   input wire logic [15:0] cop_src,
   input wire logic cop_ready,
   input wire logic cop_ans_valid,
   input wire logic [15:0] cop_ans_data,
   input wire logic [3:0] cop_ans_flags,
   input wire logic [6:0] cop_mode
);
   logic snd; // Send taken alone; mode write and load win over it
   logic div_snd; // Taken send in a divide mode
   logic [3:0] op; // Operation field of the stored mode
   logic [31:0] ext_d;
   logic [31:0] ext_s;
   logic [31:0] prod; // Low 32 bits suffice once both sides are extended
   logic [15:0] half; // Product half picked by the select field
   assign snd = clk_en && cop_ready && coproc_operand_send_instr
      && !coproc_mode_write_instr && !coproc_initial_load_instr;
   assign op = cop_mode[3:0];
   assign div_snd = snd && (op == mdc_pkg::OP_UDIV || op == mdc_pkg::OP_SDIV);
   // Sign extension only for the signed product code
   assign ext_d = (op == mdc_pkg::OP_SMUL) ? {{16{cop_dst[15]}}, cop_dst} : {16'h0000, cop_dst};
   assign ext_s = (op == mdc_pkg::OP_SMUL) ? {{16{cop_src[15]}}, cop_src} : {16'h0000, cop_src};
   assign prod = ext_d * ext_s;
   assign half = (cop_mode[6:4] == mdc_pkg::SEL_HIGH) ? prod[31:16] : prod[15:0];
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   AST_MODE_STORE: assert property (clk_en && cop_ready && coproc_mode_write_instr |=>
      cop_mode == $past(cop_src[6:0])) else $error("mode word not stored");
   AST_MUL_ANSWER: assert property (snd && (op == 4'h4 || op == 4'h5) |=>
      cop_ans_valid && cop_ans_data == $past(half) && cop_ans_flags == 4'h0)
      else $error("product answer wrong");
   AST_DIV_BUSY: assert property (div_snd |=> (!cop_ready && !cop_ans_valid) [*8])
      else $error("divide not busy");
   AST_DIV_DONE: assert property (div_snd |-> ##19 (cop_ans_valid && cop_ready))
      else $error("divide answer late or early");
   AST_INIT_QUIET: assert property (snd && op <= 4'h2 |=> !cop_ans_valid)
      else $error("answer in clear or load mode");
   AST_FLAGS: assert property (cop_ans_valid |-> (cop_ans_flags & 4'hB) == 4'h0
      && (!cop_ans_flags[2] || op == 4'h7)) else $error("flag outside overflow");
   AST_HOLD: assert property (!cop_ans_valid |-> $stable(cop_ans_data)
      && $stable(cop_ans_flags)) else $error("answer changed without pulse");
   AST_BUSY_DROP: assert property (!cop_ready && coproc_mode_write_instr |=>
      $stable(cop_mode)) else $error("mode written while busy");
   AST_READY_CAUSE: assert property ($fell(cop_ready) |-> $past(div_snd))
      else $error("busy without divide");
endmodule
bind mdc_coproc mdc_coproc_asserts u_mdc_coproc_asserts (.clock(clock), .srst(srst),
   .clk_en(clk_en), .coproc_mode_write_instr(coproc_mode_write_instr),
   .coproc_operand_send_instr(coproc_operand_send_instr),
   .coproc_initial_load_instr(coproc_initial_load_instr), .cop_dst(cop_dst),
   .cop_src(cop_src), .cop_ready(cop_ready), .cop_ans_valid(cop_ans_valid),
   .cop_ans_data(cop_ans_data), .cop_ans_flags(cop_ans_flags), .cop_mode(cop_mode));

// file: tb/mdc_core_model.sv
`timescale 1ns/1ps
// Processor core model issuing coprocessor instructions
module mdc_core_model (
   input wire logic clock,
   input wire logic clk_en,
   input wire logic cop_ready,
   output logic coproc_mode_write_instr,
   output logic coproc_initial_load_instr,
   output logic coproc_operand_send_instr,
   output logic [15:0] cop_dst,
   output logic [15:0] cop_src
);
   logic [2:0] stb; // Strobes as {mode write, initial load, send}
   assign {coproc_mode_write_instr, coproc_initial_load_instr, coproc_operand_send_instr} = stb;
   // Quiet at time zero
   initial begin
      stb = 3'h0;
      cop_dst = 16'h0000;
      cop_src = 16'h0000;
   end
   // Only documented codes are handed in by the bench
   // Both operands travel in one instruction
   task automatic issue(input logic [2:0] s, input logic [15:0] d, input logic [15:0] v);
      @(negedge clock);
      stb = s;
      cop_dst = d;
      cop_src = v;
      // A busy divider stalls us; the request just stays up
      do @(posedge clock); while (!(cop_ready && clk_en));
   endtask
   // Drop strobes; operands flip so stale values never look meaningful
   task automatic idle();
      @(negedge clock);
      stb = 3'h0;
      cop_dst = ~cop_dst;
      cop_src = ~cop_src;
   endtask
endmodule

// file: tb/mdc_coproc_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: table of mode rows, then edge cases
module mdc_coproc_tb_top;
   // Mode word, action, operands, expected half and flags
   typedef struct {
      logic [6:0] mode;
      logic [1:0] kind;
      logic [15:0] dst;
      logic [15:0] src;
      logic [15:0] data;
      logic [3:0] flags;
   } mdc_row_s;
   logic clock;
   logic srst;
   logic clk_en;
   logic mode_wr;
   logic init_ld;
   logic op_send;
   logic [15:0] dst;
   logic [15:0] src;
   logic ready;
   logic ans_valid;
   logic [15:0] ans_data;
   logic [3:0] ans_flags;
   logic [6:0] mode;
   int num_errors;
   int n_tests;
   time t0;
   // Kind 0 mode only, 1 plus initial load, 2 plus send, 3 send alone
   mdc_row_s rows [20] = '{
      '{7'h04, 2'h2, 16'hFFFF, 16'hFFFF, 16'h0001, 4'h0},
      '{7'h13, 2'h2, 16'h5555, 16'h2222, 16'hFFFE, 4'h0},
      '{7'h15, 2'h2, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h0},
      '{7'h03, 2'h2, 16'h1111, 16'h2222, 16'h0001, 4'h0},
      '{7'h08, 2'h2, 16'h0064, 16'h0007, 16'h000E, 4'h0},
      '{7'h13, 2'h2, 16'h0000, 16'h0000, 16'h0002, 4'h0},
      '{7'h19, 2'h2, 16'hFF9C, 16'h0007, 16'hFFFE, 4'h0},
      '{7'h03, 2'h2, 16'h0000, 16'h0000, 16'hFFF2, 4'h0},
      '{7'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      '{7'h13, 2'h2, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      '{7'h12, 2'h1, 16'h5A5A, 16'h0000, 16'h0000, 4'h0},
      '{7'h01, 2'h1, 16'h1234, 16'hABCD, 16'h0000, 4'h0},
      '{7'h13, 2'h2, 16'h0000, 16'h0000, 16'h0000, 4'h0},
      '{7'h03, 2'h2, 16'h0000, 16'h0000, 16'hABCD, 4'h0},
      '{7'h02, 2'h1, 16'h7FFF, 16'hFFFF, 16'h0000, 4'h0},
      '{7'h07, 2'h2, 16'h0001, 16'h0001, 16'h0000, 4'h4},
      '{7'h13, 2'h2, 16'h0000, 16'h0000, 16'h8000, 4'h0},
      '{7'h17, 2'h2, 16'h0002, 16'h0003, 16'h8000, 4'h0},
      '{7'h17, 2'h3, 16'h7FFF, 16'h7FFF, 16'hBFFF, 4'h0},
      '{7'h03, 2'h2, 16'h0000, 16'h0000, 16'h0007, 4'h0}};
   mdc_coproc u_mdc_coproc (.clock(clock), .srst(srst), .clk_en(clk_en),
      .coproc_mode_write_instr(mode_wr), .coproc_operand_send_instr(op_send),
      .coproc_initial_load_instr(init_ld), .cop_dst(dst), .cop_src(src),
      .cop_ready(ready), .cop_ans_valid(ans_valid), .cop_ans_data(ans_data),
      .cop_ans_flags(ans_flags), .cop_mode(mode));
   mdc_core_model u_mdc_core_model (.clock(clock), .clk_en(clk_en), .cop_ready(ready),
      .coproc_mode_write_instr(mode_wr), .coproc_initial_load_instr(init_ld),
      .coproc_operand_send_instr(op_send), .cop_dst(dst), .cop_src(src));
   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Compare and count; report at once on a mismatch
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Single exit for the whole run
   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Drop the strobe, then wait a bounded time for the answer pulse
   task automatic get_ans(input logic [15:0] exp_d, input logic [3:0] exp_f);
      int i;
      u_mdc_core_model.idle();
      for (i = 0; i < 30 && ans_valid !== 1'b1; i++) begin
         @(negedge clock);
      end
      check("answer pulse", {15'h0000, ans_valid}, 16'h0001);
      check("answer data", ans_data, exp_d);
      check("answer flags", {12'h000, ans_flags}, {12'h000, exp_f});
   endtask
   // Main sequence
   initial begin
      srst = 1'b1;
      clk_en = 1'b1;
      num_errors = 0;
      n_tests = 0;
      repeat (8) @(negedge clock);
      check("reset mode", {9'h000, mode}, 16'h0000);
      check("reset data", ans_data, 16'h0000);
      check("reset ready", {15'h0000, ready}, 16'h0001);
      srst = 1'b0;
      // Junk above bit 6 and in the destination must not reach the mode
      for (int i = 0; i < 20; i++) begin
         if (rows[i].kind != 2'h3) begin
            u_mdc_core_model.issue(3'h4, 16'hA5A5, {9'h1A5, rows[i].mode});
         end
         if (rows[i].kind == 2'h1) begin
            u_mdc_core_model.issue(3'h2, rows[i].dst, rows[i].src);
         end
         if (rows[i].kind[1]) begin
            u_mdc_core_model.issue(3'h1, rows[i].dst, rows[i].src);
            get_ans(rows[i].data, rows[i].flags);
         end else begin
            u_mdc_core_model.idle();
         end
         check("mode", {9'h000, mode}, {9'h000, rows[i].mode});
      end
      // Mode write held up by a running divide, taken when it ends
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0008);
      u_mdc_core_model.issue(3'h1, 16'hFFFF, 16'h0010);
      t0 = $time;
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0013);
      check("divide cycles", 16'(($time - t0) / 10), 16'h0013);
      u_mdc_core_model.idle();
      check("quotient held", ans_data, 16'h0FFF);
      check("late mode", {9'h000, mode}, 16'h0013);
      u_mdc_core_model.issue(3'h1, 16'h0000, 16'h0000);
      get_ans(16'h000F, 4'h0);
      // Overflowing accumulate leaves a raised flag for the quiet send to keep
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0002);
      u_mdc_core_model.issue(3'h2, 16'h7FFF, 16'hFFFF);
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0017);
      u_mdc_core_model.issue(3'h1, 16'h0001, 16'h0001);
      get_ans(16'h8000, 4'h4);
      // Send in clear mode gives no answer and leaves the last answer standing
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0000);
      u_mdc_core_model.issue(3'h1, 16'h1234, 16'h5678);
      u_mdc_core_model.idle();
      check("quiet send", {15'h0000, ans_valid}, 16'h0000);
      check("flags held", {12'h000, ans_flags}, 16'h0004);
      check("data held", ans_data, 16'h8000);
      // Frozen clock enable stretches a signed product
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0015);
      @(negedge clock);
      clk_en = 1'b0;
      fork
         u_mdc_core_model.issue(3'h1, 16'h0003, 16'hFFFE);
         begin
            repeat (3) @(negedge clock);
            check("frozen", {15'h0000, ans_valid}, 16'h0000);
            clk_en = 1'b1;
         end
      join
      get_ans(16'hFFFF, 4'h0);
      // Mid-run reset, two edges long so the checker's history is clean again
      @(negedge clock);
      srst = 1'b1;
      repeat (2) @(negedge clock);
      srst = 1'b0;
      check("reset mode again", {9'h000, mode}, 16'h0000);
      check("reset data again", ans_data, 16'h0000);
      // Upper half read after reset shows the result was wiped
      u_mdc_core_model.issue(3'h4, 16'h0000, 16'h0013);
      u_mdc_core_model.issue(3'h1, 16'h0000, 16'h0000);
      get_ans(16'h0000, 4'h0);
      stop_test();
   end
   // Watchdog far beyond the few hundred cycles the run needs
   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      stop_test();
   end
endmodule
